// [rtl/acc_pkg.sv]
package acc_pkg;

  // ************************************************************
  // widths and response codes
  // ************************************************************
  localparam int AXI_ADDR_W = 32;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;
  localparam int REG_ADDR_W = 8;
  localparam int DRP_ADDR_W = 10;
  localparam int DRP_DATA_W = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ************************************************************
  // far register map pages
  // ************************************************************
  localparam logic [31:0] CFG_PAGE_BASE  = 32'h0000_0000;
  localparam logic [31:0] STAT_PAGE_BASE = 32'h0000_0200;
  localparam logic [31:0] PAGE_SIZE      = 32'h0000_0200;

  // ************************************************************
  // local register port map
  // ************************************************************
  localparam logic [7:0] REG_ADDR   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_SNAP   = 8'h14;

  localparam int CTRL_RD_BIT   = 0;
  localparam int CTRL_WR_BIT   = 1;
  localparam int CTRL_STRB_LSB = 4;

  localparam int STS_BUSY      = 0;
  localparam int STS_DONE      = 1;
  localparam int STS_RD_ERR    = 2;
  localparam int STS_WR_ERR    = 3;
  localparam int STS_LANE_MODE = 4;
  localparam int STS_SWITCHING = 5;
  localparam int STS_STAT_PAGE = 6;
  localparam int STS_ALIGNED   = 7;

  localparam logic [3:0] STRB_RESET = 4'hf;

  // ************************************************************
  // lane mode reconfiguration
  // ************************************************************
  localparam logic [9:0]  DRP_COMMON_ADDR  = 10'h000;
  localparam logic [9:0]  DRP_CHANNEL_ADDR = 10'h001;
  localparam logic [15:0] DRP_CAUI10_VAL   = 16'h0000;
  localparam logic [15:0] DRP_CAUI4_VAL    = 16'h0001;
  localparam int          CORE_RESET_CYCLES = 4;
  localparam int          MODE_MIN_HIGH     = 2;

  typedef enum logic {LANE_CAUI10, LANE_CAUI4} lane_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_ACK} access_state_t;
  typedef enum logic [2:0] {SQ_IDLE, SQ_COMMON, SQ_CHANNEL, SQ_RESET, SQ_ALIGN} seq_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
  } axi_wr_t;

  typedef struct packed {
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_rd_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic        sel_channel;
    logic [9:0]  addr;
    logic [15:0] di;
  } drp_req_t;

endpackage

// [rtl/mode_request_qualifier.sv]
`timescale 1ns/1ps
`default_nettype none
module mode_request_qualifier
#(
  parameter int MIN_HIGH = acc_pkg::MODE_MIN_HIGH
)
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic request_pin,
  output var  logic start_pulse
);
  localparam int CNT_W = $clog2(MIN_HIGH + 1);

  if (MIN_HIGH < 1)
  begin : g_check
    $error("MIN_HIGH must be at least one");
  end

  logic             meta_reg;
  logic             sync_reg;
  logic             prev_reg;
  logic [CNT_W-1:0] high_cnt_reg;

  wire qualified = high_cnt_reg == CNT_W'(MIN_HIGH);
  wire fell      = prev_reg && !sync_reg;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      meta_reg     <= 1'b0;
      sync_reg     <= 1'b0;
      prev_reg     <= 1'b0;
      high_cnt_reg <= '0;
      start_pulse  <= 1'b0;
    end
    else
    begin
      meta_reg    <= request_pin;
      sync_reg    <= meta_reg;
      prev_reg    <= sync_reg;
      start_pulse <= fell && qualified; // [RULE1]
      if (!sync_reg)
        high_cnt_reg <= '0;
      else if (!qualified)
        high_cnt_reg <= high_cnt_reg + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// [rtl/lane_mode_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module lane_mode_sequencer
#(
  parameter int RESET_CYCLES = acc_pkg::CORE_RESET_CYCLES
)
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                start,
  input  wire logic                aligned,
  input  wire logic                drp_rdy,
  output var  acc_pkg::drp_req_t   drp,
  output var  logic                hold_reset,
  output var  logic                core_reset,
  output var  acc_pkg::lane_mode_t lane_mode,
  output var  logic                busy
);
  localparam int CNT_W = $clog2(RESET_CYCLES + 1);

  if (RESET_CYCLES < 1)
  begin : g_check
    $error("RESET_CYCLES must be at least one");
  end

  acc_pkg::seq_state_t state_reg;
  logic [CNT_W-1:0]    cnt_reg;

  // the value written flips the lane mode each time
  wire [15:0] target_val = (lane_mode == acc_pkg::LANE_CAUI10) ?
                           acc_pkg::DRP_CAUI4_VAL : acc_pkg::DRP_CAUI10_VAL;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg  <= acc_pkg::SQ_IDLE;
      cnt_reg    <= '0;
      drp        <= '0;
      hold_reset <= 1'b0;
      core_reset <= 1'b0;
      lane_mode  <= acc_pkg::LANE_CAUI10;
      busy       <= 1'b0;
    end
    else
    begin
      drp.en <= 1'b0;
      unique case (state_reg)
        acc_pkg::SQ_IDLE:
          if (start)
          begin
            hold_reset      <= 1'b1; // [RULE3]
            busy            <= 1'b1;
            drp.en          <= 1'b1; // [RULE2]
            drp.we          <= 1'b1;
            drp.sel_channel <= 1'b0;
            drp.addr        <= acc_pkg::DRP_COMMON_ADDR;
            drp.di          <= target_val;
            state_reg       <= acc_pkg::SQ_COMMON;
          end
        acc_pkg::SQ_COMMON:
          if (drp_rdy)
          begin
            drp.en          <= 1'b1; // [RULE2]
            drp.sel_channel <= 1'b1;
            drp.addr        <= acc_pkg::DRP_CHANNEL_ADDR;
            state_reg       <= acc_pkg::SQ_CHANNEL;
          end
        acc_pkg::SQ_CHANNEL:
          if (drp_rdy)
          begin
            hold_reset <= 1'b0; // [RULE3]
            lane_mode  <= (lane_mode == acc_pkg::LANE_CAUI10) ?
                          acc_pkg::LANE_CAUI4 : acc_pkg::LANE_CAUI10;
            core_reset <= 1'b1; // [RULE2]
            cnt_reg    <= CNT_W'(RESET_CYCLES - 1);
            state_reg  <= acc_pkg::SQ_RESET;
          end
        acc_pkg::SQ_RESET:
          if (cnt_reg == '0)
          begin
            core_reset <= 1'b0;
            state_reg  <= acc_pkg::SQ_ALIGN;
          end
          else
            cnt_reg <= cnt_reg - CNT_W'(1);
        acc_pkg::SQ_ALIGN:
          if (aligned) // [RULE3]
          begin
            busy      <= 1'b0;
            state_reg <= acc_pkg::SQ_IDLE;
          end
        default:
          state_reg <= acc_pkg::SQ_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtl/axi_lite_user_register_access.sv]
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE1] operator holds mode switch high two or more cycles, then its fall starts
// [RULE2] qualified switch writes common then channel, toggles lane mode, resets core
// [RULE3] hold reset up, reconfig write, hold reset down, then wait alignment
// [RULE4] after reset idle; read request first, else write request, else stay
// [RULE5] write phase drives awvalid, awaddr, wvalid, wdata and wstrb
// [RULE6] write phase leaves for finish only when bvalid and bready both high
// [RULE7] write answered with slave error sets the write error flag
// [RULE8] read phase drives arvalid with araddr
// [RULE9] read phase leaves for finish only when rvalid and rready both high
// [RULE10] read answered with slave error sets the read error flag
// [RULE11] finish phase lasts one cycle, then back to idle
// [RULE12] one clock, active high reset sampled on that clock
// [RULE13] addresses and data 32 bits, 4-bit byte lane strobe
// [RULE14] responses are two bits: okay, exokay, slave error, decode error
// [RULE15] one-cycle snapshot pulse captures statistics and clears accumulators
// [RULE16] any configuration register can be written through the bus
// [RULE17] any status or statistics register can be read through the bus
// [RULE18] configuration page at zero, status and statistics page at 0x200
// [RULE19] unmapped addresses are reserved and may be answered with an error
// [RULE20] finish phase flags completion with read data; new request clears errors
module axi_lite_user_register_access
(
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr_strobe,
  input  wire logic               reg_rd_strobe,
  output var  logic [31:0]        reg_rdata,
  output var  acc_pkg::axi_wr_t   axi_wr,
  input  wire logic               axi_awready,
  input  wire logic               axi_wready,
  input  wire logic               axi_bvalid,
  input  wire logic [1:0]         axi_bresp,
  output var  acc_pkg::axi_rd_t   axi_rd,
  input  wire logic               axi_arready,
  input  wire logic               axi_rvalid,
  input  wire logic [31:0]        axi_rdata,
  input  wire logic [1:0]         axi_rresp,
  output var  logic               stats_snapshot_pulse,
  output var  logic               bus_sync_reset_in,
  input  wire logic               mode_switch_req,
  input  wire logic               rx_aligned,
  output var  acc_pkg::drp_req_t  drp,
  input  wire logic               drp_rdy,
  output var  logic               drp_hold_reset,
  output var  logic               core_reset,
  output var  acc_pkg::lane_mode_t lane_mode
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic aligned_meta_reg;
  logic aligned_reg;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      aligned_meta_reg <= 1'b0;
      aligned_reg      <= 1'b0;
    end
    else
    begin
      aligned_meta_reg <= rx_aligned;
      aligned_reg      <= aligned_meta_reg;
    end
  end

  // ************************************************************
  // lane mode switch
  // ************************************************************
  logic switch_start;
  logic switch_busy;

  mode_request_qualifier #(
    .MIN_HIGH (acc_pkg::MODE_MIN_HIGH)
  ) u_qualifier (
    .clock       (clock),
    .reset       (reset),
    .request_pin (mode_switch_req),
    .start_pulse (switch_start)
  );

  lane_mode_sequencer #(
    .RESET_CYCLES (acc_pkg::CORE_RESET_CYCLES)
  ) u_sequencer (
    .clock      (clock),
    .reset      (reset),
    .start      (switch_start),
    .aligned    (aligned_reg),
    .drp_rdy    (drp_rdy),
    .drp        (drp),
    .hold_reset (drp_hold_reset),
    .core_reset (core_reset),
    .lane_mode  (lane_mode),
    .busy       (switch_busy)
  );

  // ************************************************************
  // register port decode
  // ************************************************************
  logic [31:0]            addr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             strb_reg;
  logic [31:0]            rdata_cap_reg;
  logic                   rd_req_reg;
  logic                   wr_req_reg;
  logic                   done_reg;
  logic                   rd_err_reg;
  logic                   wr_err_reg;
  acc_pkg::access_state_t state_reg;
  acc_pkg::access_state_t state_next;

  wire sel_addr   = reg_addr == acc_pkg::REG_ADDR;
  wire sel_wdata  = reg_addr == acc_pkg::REG_WDATA;
  wire sel_ctrl   = reg_addr == acc_pkg::REG_CTRL;
  wire sel_status = reg_addr == acc_pkg::REG_STATUS;
  wire sel_rdata  = reg_addr == acc_pkg::REG_RDATA;
  wire wr_addr    = reg_wr_strobe && sel_addr;
  wire wr_wdata   = reg_wr_strobe && sel_wdata;
  wire wr_ctrl    = reg_wr_strobe && sel_ctrl;
  wire wr_snap    = reg_wr_strobe && (reg_addr == acc_pkg::REG_SNAP);
  wire set_rd     = wr_ctrl && reg_wdata[acc_pkg::CTRL_RD_BIT];
  wire set_wr     = wr_ctrl && reg_wdata[acc_pkg::CTRL_WR_BIT];

  // informational only: the far side decides what is reserved
  wire in_stat_page = (addr_reg >= acc_pkg::STAT_PAGE_BASE) &&
                      (addr_reg <  acc_pkg::STAT_PAGE_BASE + acc_pkg::PAGE_SIZE); // [RULE18]

  wire busy = (state_reg != acc_pkg::ST_IDLE) || rd_req_reg || wr_req_reg;

  wire [31:0] status_word = {24'h00_0000,
                             aligned_reg,
                             in_stat_page,
                             switch_busy,
                             lane_mode == acc_pkg::LANE_CAUI4,
                             wr_err_reg,
                             rd_err_reg,
                             done_reg,
                             busy};

  wire [31:0] ctrl_word = {24'h00_0000, strb_reg, 4'h0};

  wire [31:0] read_mux = sel_addr   ? addr_reg      :
                         sel_wdata  ? wdata_reg     :
                         sel_ctrl   ? ctrl_word     :
                         sel_status ? status_word   :
                         sel_rdata  ? rdata_cap_reg : 32'h0000_0000;

  // ************************************************************
  // access state machine
  // ************************************************************
  wire idle      = state_reg == acc_pkg::ST_IDLE;
  wire accept_rd = idle && rd_req_reg; // [RULE4]
  wire accept_wr = idle && !rd_req_reg && wr_req_reg;
  wire accept    = accept_rd || accept_wr;
  wire aw_fire   = axi_wr.awvalid && axi_awready;
  wire w_fire    = axi_wr.wvalid && axi_wready;
  wire ar_fire   = axi_rd.arvalid && axi_arready;
  wire b_fire    = (state_reg == acc_pkg::ST_WRITE) && axi_bvalid && axi_wr.bready;
  wire r_fire    = (state_reg == acc_pkg::ST_READ) && axi_rvalid && axi_rd.rready;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      acc_pkg::ST_IDLE:
        if (rd_req_reg)
          state_next = acc_pkg::ST_READ; // [RULE4]
        else if (wr_req_reg)
          state_next = acc_pkg::ST_WRITE;
      acc_pkg::ST_WRITE:
        if (b_fire)
          state_next = acc_pkg::ST_ACK; // [RULE6]
      acc_pkg::ST_READ:
        if (r_fire)
          state_next = acc_pkg::ST_ACK; // [RULE9]
      acc_pkg::ST_ACK:
        state_next = acc_pkg::ST_IDLE; // [RULE11]
    endcase
  end

  // ************************************************************
  // request and user registers
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (reset) // [RULE12]
    begin
      state_reg  <= acc_pkg::ST_IDLE;
      addr_reg   <= acc_pkg::CFG_PAGE_BASE;
      wdata_reg  <= 32'h0000_0000;
      strb_reg   <= acc_pkg::STRB_RESET;
      rd_req_reg <= 1'b0;
      wr_req_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (wr_addr)
        addr_reg <= reg_wdata;
      if (wr_wdata)
        wdata_reg <= reg_wdata;
      if (wr_ctrl)
        strb_reg <= reg_wdata[acc_pkg::CTRL_STRB_LSB +: 4];
      // a new request in the accepting cycle survives
      rd_req_reg <= set_rd || (rd_req_reg && !accept_rd);
      wr_req_reg <= set_wr || (wr_req_reg && !accept_wr);
    end
  end

  // ************************************************************
  // bus master outputs
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      axi_wr <= '0;
      axi_rd <= '0;
    end
    else
    begin
      if (accept_wr)
      begin
        axi_wr.awvalid <= 1'b1; // [RULE5]
        axi_wr.awaddr  <= addr_reg; // [RULE16]
        axi_wr.wvalid  <= 1'b1;
        axi_wr.wdata   <= wdata_reg;
        axi_wr.wstrb   <= strb_reg; // [RULE13]
        axi_wr.bready  <= 1'b1;
      end
      else
      begin
        if (aw_fire)
          axi_wr.awvalid <= 1'b0;
        if (w_fire)
          axi_wr.wvalid <= 1'b0;
        if (b_fire)
          axi_wr.bready <= 1'b0;
      end
      if (accept_rd)
      begin
        axi_rd.arvalid <= 1'b1; // [RULE8]
        axi_rd.araddr  <= addr_reg; // [RULE17]
        axi_rd.rready  <= 1'b1;
      end
      else
      begin
        if (ar_fire)
          axi_rd.arvalid <= 1'b0;
        if (r_fire)
          axi_rd.rready <= 1'b0;
      end
    end
  end

  // ************************************************************
  // completion and error flags
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rdata_cap_reg <= 32'h0000_0000;
      done_reg      <= 1'b0;
      rd_err_reg    <= 1'b0;
      wr_err_reg    <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        done_reg   <= 1'b0; // [RULE20]
        rd_err_reg <= 1'b0;
        wr_err_reg <= 1'b0;
      end
      if (state_reg == acc_pkg::ST_ACK)
        done_reg <= 1'b1; // [RULE20]
      if (r_fire)
      begin
        rdata_cap_reg <= axi_rdata;
        rd_err_reg    <= axi_rresp == acc_pkg::RESP_SLVERR; // [RULE10] [RULE14] [RULE19]
      end
      if (b_fire)
        wr_err_reg <= axi_bresp == acc_pkg::RESP_SLVERR; // [RULE7] [RULE14] [RULE19]
    end
  end

  // ************************************************************
  // register read port, snapshot and far reset
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      reg_rdata            <= 32'h0000_0000;
      stats_snapshot_pulse <= 1'b0;
      bus_sync_reset_in    <= 1'b1;
    end
    else
    begin
      reg_rdata            <= reg_rd_strobe ? read_mux : 32'h0000_0000;
      stats_snapshot_pulse <= wr_snap; // [RULE15]
      // the core reset also restarts the register slave
      bus_sync_reset_in    <= core_reset; // [RULE2]
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_idle_after_reset: assert property (@(posedge clock) disable iff (1'b0)
    reset |=> state_reg == acc_pkg::ST_IDLE) // [RULE4]
    else $error("not idle after reset");
  a_read_wins: assert property (
    idle && rd_req_reg |=> state_reg == acc_pkg::ST_READ && axi_rd.arvalid) // [RULE4]
    else $error("pending read not taken first");
  a_write_taken: assert property (
    idle && !rd_req_reg && wr_req_reg |=> state_reg == acc_pkg::ST_WRITE) // [RULE4]
    else $error("pending write not taken");
  a_write_drives: assert property (
    accept_wr |=> axi_wr.awvalid && axi_wr.wvalid && axi_wr.awaddr == $past(addr_reg)
      && axi_wr.wstrb == $past(strb_reg)) // [RULE5]
    else $error("write channels not driven");
  a_write_holds: assert property (
    state_reg == acc_pkg::ST_WRITE && !(axi_bvalid && axi_wr.bready)
      |=> state_reg == acc_pkg::ST_WRITE) // [RULE6]
    else $error("write phase left early");
  a_write_error: assert property (
    b_fire |=> wr_err_reg == ($past(axi_bresp) == acc_pkg::RESP_SLVERR)) // [RULE7]
    else $error("write error flag wrong");
  a_read_drives: assert property (
    accept_rd |=> axi_rd.arvalid && axi_rd.araddr == $past(addr_reg)) // [RULE8]
    else $error("read address not driven");
  a_read_holds: assert property (
    state_reg == acc_pkg::ST_READ && !(axi_rvalid && axi_rd.rready)
      |=> state_reg == acc_pkg::ST_READ) // [RULE9]
    else $error("read phase left early");
  a_read_error: assert property (
    r_fire |=> ##1 rd_err_reg == ($past(axi_rresp, 2) == acc_pkg::RESP_SLVERR)
      && done_reg && rdata_cap_reg == $past(axi_rdata, 2)) // [RULE10]
    else $error("read error or data wrong");
  a_finish_once: assert property (
    state_reg == acc_pkg::ST_ACK |=> idle ##0 done_reg) // [RULE11]
    else $error("finish phase not one cycle");
  a_snap_cause: assert property (
    stats_snapshot_pulse |-> $past(wr_snap)) // [RULE15]
    else $error("snapshot pulse without write");
  a_mode_switch: assert property (
    switch_start |=> drp.en && !drp.sel_channel && drp_hold_reset) // [RULE2]
    else $error("switch did not start common write");
  c_write_ok: cover property (b_fire && axi_bresp == acc_pkg::RESP_OKAY);
  c_write_err: cover property (b_fire && axi_bresp == acc_pkg::RESP_SLVERR);
  c_read_err: cover property (r_fire && axi_rresp == acc_pkg::RESP_SLVERR);
  c_lane_switch: cover property (core_reset ##[1:300] !switch_busy);

endmodule
`default_nettype wire

// [sim/reg_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// register slave and reconfiguration port model
// ************************************************************
module reg_slave_model
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              slow,
  input  wire acc_pkg::axi_wr_t  axi_wr,
  output var  logic              w_ack,
  output var  logic              bvalid,
  output var  logic [1:0]        bresp,
  input  wire acc_pkg::axi_rd_t  axi_rd,
  output var  logic              r_ack,
  output var  logic              rvalid,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  input  wire acc_pkg::drp_req_t drp,
  output var  logic              drp_rdy
);
  logic [31:0] mem [0:255];
  logic [31:0] rd_q;
  logic [1:0]  tick = 2'h0;
  logic [1:0]  drp_pipe = 2'h0;
  wire go = !slow || tick == 2'h3;
  wire wr_bad = axi_wr.awaddr[31:10] != 22'h0;
  wire rd_bad = axi_rd.araddr[31:10] != 22'h0;
  // released read bus shows the inverse so a stale copy never passes
  assign rdata = rvalid ? rd_q : ~rd_q;
  assign drp_rdy = drp_pipe[1];
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  always @(posedge clock)
  begin
    tick <= tick + 2'h1;
    drp_pipe <= {drp_pipe[0], drp.en};
    w_ack <= axi_wr.awvalid && axi_wr.wvalid && go && !w_ack && !bvalid;
    r_ack <= axi_rd.arvalid && go && !r_ack && !rvalid;
    if (w_ack)
    begin
      bvalid <= 1'b1;
      bresp <= wr_bad ? acc_pkg::RESP_SLVERR : acc_pkg::RESP_OKAY;
      for (int b = 0; b < 4; b++)
        if (axi_wr.wstrb[b] && !wr_bad)
          mem[axi_wr.awaddr[9:2]][b*8 +: 8] <= axi_wr.wdata[b*8 +: 8];
    end
    else if (bvalid && axi_wr.bready)
      bvalid <= 1'b0;
    if (r_ack)
    begin
      rvalid <= 1'b1;
      rd_q <= mem[axi_rd.araddr[9:2]];
      rresp <= rd_bad ? acc_pkg::RESP_SLVERR : acc_pkg::RESP_OKAY;
    end
    else if (rvalid && axi_rd.rready)
      rvalid <= 1'b0;
    if (reset)
    begin
      w_ack <= 1'b0;
      r_ack <= 1'b0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr_strobe = 1'b0;
  logic reg_rd_strobe = 1'b0;
  logic mode_switch_req = 1'b0;
  logic rx_aligned = 1'b0;
  logic slow = 1'b0;
  logic [31:0] reg_rdata, rdata;
  acc_pkg::axi_wr_t axi_wr;
  acc_pkg::axi_rd_t axi_rd;
  acc_pkg::drp_req_t drp;
  acc_pkg::lane_mode_t lane_mode;
  logic w_ack, bvalid, r_ack, rvalid, snap, bsr, hold, core_reset, drp_rdy;
  logic [1:0] bresp, rresp;
  logic [31:0] seed = 32'h0001_37c1;
  logic [31:0] shadow [0:255];
  logic [15:0] last_di [0:1];
  int n_mismatch = 0;
  int n_checks = 0;
  int n_en = 0;
  int n_core = 0;
  int n_snap = 0;
  logic m = acc_pkg::LANE_CAUI10;
  always #10 clock = ~clock;
  axi_lite_user_register_access axi_lite_user_register_access_i (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_strobe(reg_wr_strobe),
    .reg_rd_strobe(reg_rd_strobe), .reg_rdata(reg_rdata), .axi_wr(axi_wr),
    .axi_awready(w_ack), .axi_wready(w_ack), .axi_bvalid(bvalid), .axi_bresp(bresp),
    .axi_rd(axi_rd), .axi_arready(r_ack), .axi_rvalid(rvalid), .axi_rdata(rdata),
    .axi_rresp(rresp), .stats_snapshot_pulse(snap), .bus_sync_reset_in(bsr),
    .mode_switch_req(mode_switch_req), .rx_aligned(rx_aligned), .drp(drp),
    .drp_rdy(drp_rdy), .drp_hold_reset(hold), .core_reset(core_reset), .lane_mode(lane_mode));
  reg_slave_model reg_slave_model_i (.clock(clock), .reset(reset), .slow(slow),
    .axi_wr(axi_wr), .w_ack(w_ack), .bvalid(bvalid), .bresp(bresp), .axi_rd(axi_rd),
    .r_ack(r_ack), .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .drp(drp), .drp_rdy(drp_rdy));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_strobe <= 1'b1;
    @(posedge clock);
    reg_wr_strobe <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd_strobe <= 1'b1;
    @(posedge clock);
    reg_rd_strobe <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic xfer(bit is_rd, logic [31:0] a, logic [31:0] d, logic [3:0] s);
    logic [31:0] st;
    logic bad;
    bad = a[31:10] != 22'h0;
    st = 32'h0;
    wr(acc_pkg::REG_ADDR, a);
    wr(acc_pkg::REG_WDATA, d);
    wr(acc_pkg::REG_CTRL, {24'h0, s, 2'b00, !is_rd, is_rd});
    for (int i = 0; i < 60 && st[acc_pkg::STS_DONE] !== 1'b1; i++)
      rd(acc_pkg::REG_STATUS, st);
    check("done", 32'h1, st[acc_pkg::STS_DONE]);
    check("error", bad, st[is_rd ? acc_pkg::STS_RD_ERR : acc_pkg::STS_WR_ERR]);
    check("stale error", 32'h0, st[is_rd ? acc_pkg::STS_WR_ERR : acc_pkg::STS_RD_ERR]);
    check("status page", a >= 32'h200 && a < 32'h400, st[acc_pkg::STS_STAT_PAGE]);
    if (is_rd)
    begin
      rd(acc_pkg::REG_RDATA, st);
      if (!bad)
        check("read data", shadow[a[9:2]], st);
    end
    else
      for (int b = 0; b < 4; b++)
        if (s[b] && !bad)
          shadow[a[9:2]][b*8 +: 8] = d[b*8 +: 8];
  endtask
  task automatic mode_switch(int hi, bit take);
    n_en = 0;
    n_core = 0;
    rx_aligned <= 1'b0;
    @(posedge clock);
    mode_switch_req <= 1'b1;
    repeat (hi) @(posedge clock);
    mode_switch_req <= 1'b0;
    repeat (40) @(posedge clock);
    check("reconfig writes", take ? 2 : 0, n_en);
    check("reset cycles", take ? 8 : 0, n_core);
    check("lane mode", take ? !m : m, lane_mode);
    if (take)
      check("channel value", m == acc_pkg::LANE_CAUI10 ? acc_pkg::DRP_CAUI4_VAL :
            acc_pkg::DRP_CAUI10_VAL, last_di[1]);
    m ^= take;
    rx_aligned <= 1'b1;
    repeat (10) @(posedge clock);
  endtask
  always @(posedge clock)
  begin
    if (drp.en)
    begin
      n_en++;
      last_di[drp.sel_channel] = drp.di;
      if (drp.sel_channel)
        check("hold reset", 32'h1, hold);
    end
    n_core += core_reset + bsr;
    n_snap += snap;
  end
  initial
  begin
    logic [31:0] a;
    for (int i = 0; i < 256; i++) shadow[i] = 32'h0;
    repeat (4) @(posedge clock);
    check("slave reset", 32'h1, bsr);
    @(posedge clock);
    reset <= 1'b0;
    rx_aligned <= 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      seed = lfsr(seed);
      a = {22'h0, seed[9:2], 2'b00};
      // about one target in eight lies outside the map and must be refused
      if (seed[12:10] == 3'h0)
        a[15] = 1'b1;
      slow <= seed[20];
      xfer(1'b0, a, lfsr(seed), k == 0 ? 4'h0 : seed[19:16]);
      xfer(1'b1, a, 32'h0, 4'h0);
    end
    n_snap = 0;
    wr(acc_pkg::REG_SNAP, seed);
    repeat (4) @(posedge clock);
    check("snapshot pulses", 32'h1, n_snap);
    mode_switch(1, 1'b0);
    mode_switch(2, 1'b1);
    mode_switch(3, 1'b1);
    end_sim();
  end
  // generous limit, the full run needs only about a thousand cycles
  initial
  begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
